// [include/program_map_pkg.sv]
// Shared constants and types for the program memory partition map
package program_map_pkg;
    localparam int ADDR_W = 15;
    localparam int WORD_W = 14;
    localparam int MEM_AW = 13;
    localparam logic [12:0] SMALL_LAST = 13'h0fff;
    localparam logic [12:0] LARGE_LAST = 13'h1fff;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004;
    localparam logic [15:0] REVISION_OFFSET = 16'h8005;
    localparam logic [15:0] IDENTITY_OFFSET = 16'h8006;
    localparam int CONFIG_SPACE_BIT = 15;
    localparam logic [1:0] ID_FIXED_BITS = 2'h3;
    localparam logic [1:0] REV_FIXED_BITS = 2'h2;
    localparam int IND_PROG_BIT = 7;
    localparam logic [2:0] BOOT_SIZE_TOP_CODE = 3'h7;
    localparam logic [12:0] BOOT_BASE_WORDS = 13'h0200;
    localparam logic [2:0] SMALL_SHIFT_CAP = 3'h2;
    localparam logic [2:0] LARGE_SHIFT_CAP = 3'h3;
    localparam logic [12:0] STORAGE_SPAN_LAST = 13'h007f;
    localparam int LOCK_APP = 0;
    localparam int LOCK_BOOT = 1;
    localparam int LOCK_CFG = 2;
    localparam int LOCK_STORE = 3;
    localparam logic [3:0] LOCK_RESET = 4'hf;
    localparam int CFG_SIZE_LSB = 4;
    localparam int CFG_STORE_EN_N = 7;
    localparam int CFG_BOOT_EN_N = 8;
    localparam logic [8:0] CFG_RESET = 9'h1ff;
    localparam logic FLAG_RESET = 1'b1;
    localparam logic [13:0] WORD_RESET = 14'h0000;
    typedef enum logic [1:0] {PORT_IDLE, PORT_FETCH, PORT_IND, PORT_NVM} port_owner_t;
endpackage

// [hw/partition_decoder.sv]
// Classifies a wrapped program address into boot, application or storage partition
`timescale 1ns/1ps
module partition_decoder
    import program_map_pkg::*;
#(
    parameter bit LARGE = 1'b1
)
(
    input  wire logic [12:0] addr,
    input  wire logic        boot_en,
    input  wire logic        storage_en,
    input  wire logic [2:0]  size_sel,
    output logic             in_boot,
    output logic             in_storage,
    output logic             in_app,
    output logic             exec_ok
);
    logic [12:0] last;
    logic [2:0]  shift;
    logic [2:0]  cap;
    logic [2:0]  eff;
    logic [12:0] boot_last;

    assign last = LARGE ? LARGE_LAST : SMALL_LAST;
    assign cap = LARGE ? LARGE_SHIFT_CAP : SMALL_SHIFT_CAP;
    // Each lower code doubles the block, capped at half memory
    assign shift = BOOT_SIZE_TOP_CODE - size_sel;
    assign eff = (shift > cap) ? cap : shift;
    assign boot_last = (BOOT_BASE_WORDS << eff) - 13'h0001;
    assign in_storage = storage_en && (addr >= last - STORAGE_SPAN_LAST);
    assign in_boot = boot_en && (addr <= boot_last) && !in_storage;
    assign in_app = !in_boot && !in_storage;
    assign exec_ok = !in_storage;
endmodule

// [hw/program_word_store.sv]
// Program word array with one registered read port and one write port
`timescale 1ns/1ps
module program_word_store
    import program_map_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic [MEM_AW-1:0] raddr,
    input  wire logic              we,
    input  wire logic [MEM_AW-1:0] waddr,
    input  wire logic [WORD_W-1:0] wdata,
    output logic      [WORD_W-1:0] rdata_q
);
    logic [WORD_W-1:0] mem [0:(1<<MEM_AW)-1];

    always_ff @(posedge clock)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= WORD_RESET;
        else
            rdata_q <= mem[raddr];
    end
endmodule

// [hw/program_memory_partition_map.sv]
// Program memory map: identity words, fetch, indirect reads, partitions and locks
// Summary of operation
// - Identity word: part code, bits 13:12 one
// - Revision word read-only, bits 13:12 are 10
// - Revision bits 11:6 hold major step
// - Revision bits 5:0 hold minor step
// - Fifteen-bit counter over 14-bit words
// - Addresses wrap within implemented size
// - Start at 0000h, interrupt vector 0004h
// - Pointer bit 7 reads program word low byte
// - Indirect writes never change program memory
// - Indirect program read costs one extra cycle
// - Defaults make all flash application
// - Boot enable carves boot block from zero
// - Storage enable reserves top 128 words
// - Storage partition is not executable
// - Write lock per partition and configuration
// - Locked write ignored, sets write error
// - Bad execution resets, clears violation flag
// - Boot size code doubles, capped at half
// - Lock zero protects; only bulk erase or reset clears
`timescale 1ns/1ps
module program_memory_partition_map
    import program_map_pkg::*;
#(
    parameter bit          LARGE_VARIANT = 1'b1,
    parameter logic [11:0] PART_CODE     = 12'h5a5,  // Arbitrary value
    parameter logic [5:0]  MAJOR_STEP    = 6'h01,    // Arbitrary value
    parameter logic [5:0]  MINOR_STEP    = 6'h02     // Arbitrary value
)
(
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic        BOOT_PART_ENABLE_N,
    input  wire logic        STORAGE_PART_ENABLE_N,
    input  wire logic [2:0]  BOOT_PART_SIZE_SEL,
    input  wire logic        APP_PART_WRITE_LOCK,
    input  wire logic        BOOT_PART_WRITE_LOCK,
    input  wire logic        CONFIG_WRITE_LOCK,
    input  wire logic        STORAGE_PART_WRITE_LOCK,
    input  wire logic        BULK_ERASE,
    input  wire logic        FETCH_NEXT,
    input  wire logic        JUMP_LOAD,
    input  wire logic [14:0] JUMP_ADDR,
    input  wire logic        INT_TAKE,
    output logic      [14:0] PROGRAM_COUNTER,
    output logic             FETCH_STALL,
    output logic      [13:0] INSTR_WORD,
    output logic      [14:0] INSTR_ADDR,
    output logic             INSTR_VALID,
    input  wire logic [7:0]  INDIRECT_POINTER_HIGH,
    input  wire logic [7:0]  INDIRECT_POINTER_LOW,
    input  wire logic        INDIRECT_READ,
    input  wire logic        INDIRECT_WRITE,
    output logic             INDIRECT_STALL,
    output logic      [7:0]  INDIRECT_DATA,
    output logic             INDIRECT_VALID,
    output logic             DATA_MEM_WRITE,
    input  wire logic        NVM_RD_REQ,
    input  wire logic [15:0] NVM_RD_ADDR,
    output logic             NVM_RD_BUSY,
    output logic      [13:0] NVM_RD_DATA,
    output logic             NVM_RD_VALID,
    input  wire logic        NVM_WR_REQ,
    input  wire logic [15:0] NVM_WR_ADDR,
    input  wire logic [13:0] NVM_WR_DATA,
    output logic             NVM_WR_DONE,
    output logic             CONFIG_WR_GRANT,
    input  wire logic        NVM_ERR_CLEAR,
    output logic             WRITE_ERROR_FLAG,
    input  wire logic        EXEC_FLAG_SET,
    output logic             EXEC_VIOLATION_FLAG,
    output logic             EXEC_VIOLATION_RESET
);
    logic [8:0]        cfg_raw;
    logic [8:0]        cfg_s1_q;
    logic [8:0]        cfg_s2_q;
    logic [3:0]        lock_q;
    logic              boot_en;
    logic              storage_en;
    logic [2:0]        size_sel;
    logic [12:0]       last;
    logic [14:0]       pc_q;
    logic [14:0]       instr_addr_q;
    port_owner_t       owner_q;
    logic              ind_prog;
    logic              fetch_go;
    logic              nvm_go;
    logic [12:0]       mem_raddr;
    logic [13:0]       mem_rdata;
    logic [15:0]       nvm_addr_q;
    logic [13:0]       nvm_data_q;
    logic              nvm_valid_q;
    logic              wr_cfg;
    logic              wr_boot;
    logic              wr_store;
    logic              wr_app;
    logic              wr_protect;
    logic              mem_we;
    logic              wr_done_q;
    logic              cfg_grant_q;
    logic              wr_err_q;
    logic              ex_boot;
    logic              ex_store;
    logic              ex_app;
    logic              ex_ok;
    logic              violation;
    logic              viol_rst_q;
    logic              viol_flag_q;

    // Configuration fuse levels arrive from outside the clock domain
    assign cfg_raw = {BOOT_PART_ENABLE_N, STORAGE_PART_ENABLE_N, BOOT_PART_SIZE_SEL,
                      STORAGE_PART_WRITE_LOCK, CONFIG_WRITE_LOCK,
                      BOOT_PART_WRITE_LOCK, APP_PART_WRITE_LOCK};

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cfg_s1_q <= CFG_RESET;
            cfg_s2_q <= CFG_RESET;
        end
        else
        begin
            cfg_s1_q <= cfg_raw;
            cfg_s2_q <= cfg_s1_q;
        end
    end

    assign boot_en = !cfg_s2_q[CFG_BOOT_EN_N];
    assign storage_en = !cfg_s2_q[CFG_STORE_EN_N];
    assign size_sel = cfg_s2_q[CFG_SIZE_LSB +: 3];
    assign last = LARGE_VARIANT ? LARGE_LAST : SMALL_LAST;

    // A lock once cleared stays cleared until a bulk erase or a reset
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            lock_q <= LOCK_RESET;
        else if (BULK_ERASE)
            lock_q <= LOCK_RESET;
        else
            lock_q <= lock_q & cfg_s2_q[3:0];
    end

    // Read port: indirect read, then NVM read, then fetch
    assign ind_prog = INDIRECT_READ && INDIRECT_POINTER_HIGH[IND_PROG_BIT];
    assign nvm_go = NVM_RD_REQ && !ind_prog;
    assign fetch_go = FETCH_NEXT && !INT_TAKE && !JUMP_LOAD && !ind_prog && !NVM_RD_REQ;
    assign FETCH_STALL = FETCH_NEXT && !INT_TAKE && !JUMP_LOAD && !fetch_go;
    assign NVM_RD_BUSY = NVM_RD_REQ && ind_prog;
    assign INDIRECT_STALL = ind_prog;
    assign DATA_MEM_WRITE = INDIRECT_WRITE && !INDIRECT_POINTER_HIGH[IND_PROG_BIT];

    always_comb
    begin
        if (ind_prog)
            mem_raddr = {INDIRECT_POINTER_HIGH[4:0], INDIRECT_POINTER_LOW} & last;
        else if (nvm_go)
            mem_raddr = NVM_RD_ADDR[12:0] & last;
        else
            mem_raddr = pc_q[12:0] & last;
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            owner_q <= PORT_IDLE;
        else if (ind_prog)
            owner_q <= PORT_IND;
        else if (nvm_go)
            owner_q <= PORT_NVM;
        else if (fetch_go)
            owner_q <= PORT_FETCH;
        else
            owner_q <= PORT_IDLE;
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            pc_q <= RESET_VECTOR;
        else if (INT_TAKE)
            pc_q <= INT_VECTOR;
        else if (JUMP_LOAD)
            pc_q <= JUMP_ADDR;
        else if (fetch_go)
            pc_q <= pc_q + 15'h0001;
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            instr_addr_q <= RESET_VECTOR;
        else if (fetch_go)
            instr_addr_q <= pc_q;
    end

    assign PROGRAM_COUNTER = pc_q;
    assign INSTR_ADDR = instr_addr_q;
    assign INSTR_WORD = mem_rdata;
    assign INSTR_VALID = (owner_q == PORT_FETCH);
    assign INDIRECT_DATA = mem_rdata[7:0];
    assign INDIRECT_VALID = (owner_q == PORT_IND);

    // NVM reads: identity words live in configuration space
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            nvm_addr_q <= 16'h0000;
        else if (nvm_go)
            nvm_addr_q <= NVM_RD_ADDR;
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            nvm_data_q <= WORD_RESET;
            nvm_valid_q <= 1'b0;
        end
        else
        begin
            nvm_valid_q <= (owner_q == PORT_NVM);
            if (owner_q == PORT_NVM)
            begin
                if (nvm_addr_q == IDENTITY_OFFSET)
                    nvm_data_q <= {ID_FIXED_BITS, PART_CODE};
                else if (nvm_addr_q == REVISION_OFFSET)
                    nvm_data_q <= {REV_FIXED_BITS, MAJOR_STEP, MINOR_STEP};
                else if (nvm_addr_q[CONFIG_SPACE_BIT])
                    nvm_data_q <= WORD_RESET;
                else
                    nvm_data_q <= mem_rdata;
            end
        end
    end

    assign NVM_RD_DATA = nvm_data_q;
    assign NVM_RD_VALID = nvm_valid_q;

    // Write protection for controller writes
    assign wr_cfg = NVM_WR_ADDR[CONFIG_SPACE_BIT];
    assign wr_protect = wr_cfg ? !lock_q[LOCK_CFG]
                      : (wr_app && !lock_q[LOCK_APP]) || (wr_boot && !lock_q[LOCK_BOOT])
                        || (wr_store && !lock_q[LOCK_STORE]);
    assign mem_we = NVM_WR_REQ && !wr_cfg && !wr_protect;

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_done_q <= 1'b0;
            cfg_grant_q <= 1'b0;
        end
        else
        begin
            wr_done_q <= mem_we;
            cfg_grant_q <= NVM_WR_REQ && wr_cfg && !wr_protect;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            wr_err_q <= 1'b0;
        else if (NVM_WR_REQ && wr_protect)
            wr_err_q <= 1'b1;
        else if (NVM_ERR_CLEAR)
            wr_err_q <= 1'b0;
    end

    assign NVM_WR_DONE = wr_done_q;
    assign CONFIG_WR_GRANT = cfg_grant_q;
    assign WRITE_ERROR_FLAG = wr_err_q;

    // Execution from storage raises a violation reset; flag is active low
    assign violation = INSTR_VALID && !ex_ok;

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            viol_rst_q <= 1'b0;
            viol_flag_q <= FLAG_RESET;
        end
        else
        begin
            viol_rst_q <= violation;
            if (violation)
                viol_flag_q <= 1'b0;
            else if (EXEC_FLAG_SET)
                viol_flag_q <= 1'b1;
        end
    end

    assign EXEC_VIOLATION_RESET = viol_rst_q;
    assign EXEC_VIOLATION_FLAG = viol_flag_q;

    program_word_store u_store (
        .clock   (CLOCK),
        .reset_n (RESETN),
        .raddr   (mem_raddr),
        .we      (mem_we),
        .waddr   (NVM_WR_ADDR[12:0] & last),
        .wdata   (NVM_WR_DATA),
        .rdata_q (mem_rdata)
    );

    partition_decoder #(.LARGE(LARGE_VARIANT)) u_wr_map (
        .addr       (NVM_WR_ADDR[12:0] & last),
        .boot_en    (boot_en),
        .storage_en (storage_en),
        .size_sel   (size_sel),
        .in_boot    (wr_boot),
        .in_storage (wr_store),
        .in_app     (wr_app),
        .exec_ok    ()
    );

    partition_decoder #(.LARGE(LARGE_VARIANT)) u_ex_map (
        .addr       (instr_addr_q[12:0] & last),
        .boot_en    (boot_en),
        .storage_en (storage_en),
        .size_sel   (size_sel),
        .in_boot    (ex_boot),
        .in_storage (ex_store),
        .in_app     (ex_app),
        .exec_ok    (ex_ok)
    );

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    AST_ID_WORD: assert property (
        nvm_go && NVM_RD_ADDR == IDENTITY_OFFSET |-> ##2 NVM_RD_VALID
        && NVM_RD_DATA == {ID_FIXED_BITS, PART_CODE})
        else $error("identity word wrong");
    AST_REV_WORD: assert property (
        nvm_go && NVM_RD_ADDR == REVISION_OFFSET |-> ##2 NVM_RD_VALID
        && NVM_RD_DATA[13:12] == REV_FIXED_BITS)
        else $error("revision fixed bits wrong");
    AST_REV_STEPS: assert property (
        nvm_go && NVM_RD_ADDR == REVISION_OFFSET |-> ##2
        NVM_RD_DATA[11:6] == MAJOR_STEP && NVM_RD_DATA[5:0] == MINOR_STEP)
        else $error("revision steps wrong");
    AST_INT_VECTOR: assert property (
        INT_TAKE |=> PROGRAM_COUNTER == INT_VECTOR)
        else $error("interrupt vector wrong");
    AST_FETCH_ADDR: assert property (
        fetch_go |=> INSTR_VALID && INSTR_ADDR == $past(pc_q)
        && pc_q == $past(pc_q) + 15'h0001)
        else $error("fetch address wrong");
    AST_IND_EXTRA: assert property (
        ind_prog |-> (INDIRECT_STALL && !fetch_go) ##1 (INDIRECT_VALID && !INSTR_VALID))
        else $error("indirect read timing wrong");
    AST_IND_NO_WRITE: assert property (
        INDIRECT_WRITE && INDIRECT_POINTER_HIGH[IND_PROG_BIT] |-> !DATA_MEM_WRITE)
        else $error("indirect write reached memory");
    AST_LOCKED_WRITE: assert property (
        NVM_WR_REQ && wr_protect |-> !mem_we ##1 WRITE_ERROR_FLAG && !NVM_WR_DONE)
        else $error("locked write not refused");
    AST_STORE_EXEC: assert property (
        INSTR_VALID && ex_store |=> EXEC_VIOLATION_RESET && !EXEC_VIOLATION_FLAG)
        else $error("storage execution not trapped");
    AST_LOCK_STICKY: assert property (
        !BULK_ERASE |=> (lock_q & ~$past(lock_q)) == 4'h0)
        else $error("lock released without bulk erase");
    AST_APP_DEFAULT: assert property (
        !boot_en && !storage_en |-> wr_app && ex_app)
        else $error("default map not application");

    COV_VIOLATION: cover property (EXEC_VIOLATION_RESET);
    COV_LOCKED: cover property (NVM_WR_REQ && wr_protect);
    COV_INDIRECT: cover property (ind_prog ##1 INDIRECT_VALID);
    COV_BOOT_WRITE: cover property (mem_we && wr_boot);
endmodule

// [verification/nvm_side_model.sv]
// Model of the NVM controller that issues program memory reads and writes
`timescale 1ns/1ps
module nvm_side_model
(
    input  wire logic        clock,
    output logic             rd_req,
    output logic      [15:0] rd_addr,
    input  wire logic        rd_busy,
    input  wire logic [13:0] rd_data,
    input  wire logic        rd_valid,
    output logic             wr_req,
    output logic      [15:0] wr_addr,
    output logic      [13:0] wr_data,
    input  wire logic        wr_done,
    input  wire logic        cfg_grant,
    input  wire logic        err_flag,
    output logic             err_clear
);
    initial
    begin
        rd_req = 1'b0;
        rd_addr = 16'h0000;
        wr_req = 1'b0;
        wr_addr = 16'h0000;
        wr_data = 14'h0000;
        err_clear = 1'b0;
    end

    // Request is held while refused; released lines show the inverse
    task automatic rd(input logic [15:0] a, output logic [13:0] d);
        int n;
        n = 0;
        @(negedge clock);
        rd_req = 1'b1;
        rd_addr = a;
        #1;
        while (rd_busy !== 1'b0 && n < 8)
        begin
            @(negedge clock);
            #1;
            n++;
        end
        @(negedge clock);
        rd_req = 1'b0;
        rd_addr = ~a;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4)
        begin
            @(negedge clock);
            n++;
        end
        d = rd_data;
    endtask

    // Answer is sampled one cycle after the take; a set error is cleared
    task automatic wr(input logic [15:0] a, input logic [13:0] d,
                      output logic dn, output logic gr, output logic er);
        @(negedge clock);
        wr_req = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clock);
        dn = wr_done;
        gr = cfg_grant;
        er = err_flag;
        wr_req = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
        if (er === 1'b1)
        begin
            err_clear = 1'b1;
            @(negedge clock);
            err_clear = 1'b0;
        end
    endtask
endmodule

// [verification/program_memory_partition_map_tb.sv]
// Self-checking bench for the program memory partition map
`timescale 1ns/1ps
module program_memory_partition_map_tb;
    import program_map_pkg::*;
    localparam logic [11:0] PCODE = 12'h3c7; // Arbitrary value
    localparam logic [5:0]  MAJ   = 6'h15;   // Arbitrary value
    localparam logic [5:0]  MIN   = 6'h2a;   // Arbitrary value
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        boot_n = 1'b1, store_n = 1'b1, bulk = 1'b0, eset = 1'b0;
    logic [2:0]  size = 3'h7;
    logic [3:0]  lock = 4'hf;
    logic        fetch = 1'b0, jump = 1'b0, intr = 1'b0, iread = 1'b0, iwrite = 1'b0;
    logic [14:0] jaddr = 15'h0000;
    logic [7:0]  ph = 8'h00, pl = 8'h00;
    logic [14:0] pc, iaddr;
    logic [13:0] iword, rdd, wdd;
    logic        fstall, ivalid, istall, idvalid, dmw, rbusy, rvalid, wdone, grant;
    logic        werr, evf, evr, rreq, wreq, eclr;
    logic [7:0]  idata;
    logic [15:0] raddr, waddr;
    int          miscompares = 0, n_tests = 0, cycles = 0;
    logic [2:0]  size_codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h0};

    always #12.5 clock = ~clock;

    program_memory_partition_map #(.PART_CODE(PCODE), .MAJOR_STEP(MAJ), .MINOR_STEP(MIN)) u_dut
    (
        .CLOCK(clock), .RESETN(resetn), .BOOT_PART_ENABLE_N(boot_n),
        .STORAGE_PART_ENABLE_N(store_n), .BOOT_PART_SIZE_SEL(size),
        .APP_PART_WRITE_LOCK(lock[0]), .BOOT_PART_WRITE_LOCK(lock[1]),
        .CONFIG_WRITE_LOCK(lock[2]), .STORAGE_PART_WRITE_LOCK(lock[3]), .BULK_ERASE(bulk),
        .FETCH_NEXT(fetch), .JUMP_LOAD(jump), .JUMP_ADDR(jaddr), .INT_TAKE(intr),
        .PROGRAM_COUNTER(pc), .FETCH_STALL(fstall), .INSTR_WORD(iword), .INSTR_ADDR(iaddr),
        .INSTR_VALID(ivalid), .INDIRECT_POINTER_HIGH(ph), .INDIRECT_POINTER_LOW(pl),
        .INDIRECT_READ(iread), .INDIRECT_WRITE(iwrite), .INDIRECT_STALL(istall),
        .INDIRECT_DATA(idata), .INDIRECT_VALID(idvalid), .DATA_MEM_WRITE(dmw),
        .NVM_RD_REQ(rreq), .NVM_RD_ADDR(raddr), .NVM_RD_BUSY(rbusy), .NVM_RD_DATA(rdd),
        .NVM_RD_VALID(rvalid), .NVM_WR_REQ(wreq), .NVM_WR_ADDR(waddr), .NVM_WR_DATA(wdd),
        .NVM_WR_DONE(wdone), .CONFIG_WR_GRANT(grant), .NVM_ERR_CLEAR(eclr),
        .WRITE_ERROR_FLAG(werr), .EXEC_FLAG_SET(eset), .EXEC_VIOLATION_FLAG(evf),
        .EXEC_VIOLATION_RESET(evr)
    );

    nvm_side_model u_nvm
    (
        .clock(clock), .rd_req(rreq), .rd_addr(raddr), .rd_busy(rbusy), .rd_data(rdd),
        .rd_valid(rvalid), .wr_req(wreq), .wr_addr(waddr), .wr_data(wdd), .wr_done(wdone),
        .cfg_grant(grant), .err_flag(werr), .err_clear(eclr)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // Last boot word for a size code, capped at half of 8192 words
    function automatic logic [15:0] boot_last(input logic [2:0] code);
        int n;
        n = 512 << (7 - code);
        if (n > 4096)
            n = 4096;
        return 16'(n - 1);
    endfunction

    task automatic put(input logic [15:0] a, input logic [13:0] d, input logic ok, input logic er);
        logic dn, gr, e;
        u_nvm.wr(a, d, dn, gr, e);
        check(a[15] ? gr : dn, ok);
        check(e, er);
    endtask

    task automatic get(input logic [15:0] a, input logic [13:0] exp);
        logic [13:0] d;
        u_nvm.rd(a, d);
        check({2'h0, d}, {2'h0, exp});
    endtask

    task automatic settle();
        repeat (4) @(negedge clock);
    endtask

    task automatic erase();
        @(negedge clock);
        bulk = 1'b1;
        @(negedge clock);
        bulk = 1'b0;
    endtask

    task automatic fetch_at(input logic [14:0] a, input logic [13:0] w, input logic bad);
        @(negedge clock);
        jump = 1'b1;
        jaddr = a;
        @(negedge clock);
        jump = 1'b0;
        jaddr = ~a;
        fetch = 1'b1;
        check(pc, a);
        #1 check(fstall, 1'b0);
        @(negedge clock);
        fetch = 1'b0;
        check(ivalid, 1'b1);
        check(iaddr, a);
        check(iword, w);
        check(pc, a + 15'h0001);
        @(negedge clock);
        check(evr, bad);
        check(evf, !bad);
    endtask

    task automatic ind(input logic [12:0] a, input logic [7:0] exp);
        @(negedge clock);
        iread = 1'b1;
        ph = {3'h4, a[12:8]};
        pl = a[7:0];
        fetch = 1'b1;
        #1 check(istall, 1'b1);
        check(fstall, 1'b1);
        @(negedge clock);
        iread = 1'b0;
        fetch = 1'b0;
        ph = ~ph;
        pl = ~pl;
        check(ivalid, 1'b0);
        check(idvalid, 1'b1);
        check(idata, exp);
    endtask

    initial
    begin
        logic [12:0] a;
        logic [13:0] d;
        void'($urandom(32'hcff6));
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        check(pc, 16'h0000);
        check(evf, 1'b1);
        check(werr, 1'b0);
        get(16'h8006, {2'h3, PCODE});
        get(16'h8005, {2'h2, MAJ, MIN});
        $display("Test identity done");
        for (int i = 0; i < 12; i++)
        begin
            a = 13'($urandom_range(0, 8063));
            d = 14'($urandom);
            put({3'h0, a}, d, 1'b1, 1'b0);
            get(i[0] ? {3'h3, a} : {3'h1, a}, d);
            ind(a, d[7:0]);
            fetch_at({2'h0, a}, d, 1'b0);
        end
        @(negedge clock);
        intr = 1'b1;
        jump = 1'b1;
        @(negedge clock);
        intr = 1'b0;
        jump = 1'b0;
        check(pc, 16'h0004);
        iwrite = 1'b1;
        ph = {3'h4, a[12:8]};
        pl = a[7:0];
        #1 check(dmw, 1'b0);
        @(negedge clock);
        ph = 8'h00;
        #1 check(dmw, 1'b1);
        @(negedge clock);
        iwrite = 1'b0;
        get({3'h0, a}, d);
        $display("Test access done");
        put(16'h0000, 14'h0abc, 1'b1, 1'b0);
        lock[0] = 1'b0;
        settle();
        put(16'h0000, 14'h1234, 1'b0, 1'b1);
        put(16'h1fff, 14'h1234, 1'b0, 1'b1);
        lock[0] = 1'b1;
        settle();
        put(16'h0000, 14'h1234, 1'b0, 1'b1);
        get(16'h0000, 14'h0abc);
        erase();
        put(16'h0000, 14'h1234, 1'b1, 1'b0);
        put(16'h8009, 14'h0001, 1'b1, 1'b0);
        lock[2] = 1'b0;
        settle();
        put(16'h8009, 14'h0001, 1'b0, 1'b1);
        lock[2] = 1'b1;
        erase();
        $display("Test locks done");
        store_n = 1'b0;
        settle();
        put(16'h1f80, 14'h2aaa, 1'b1, 1'b0);
        put(16'h1f7f, 14'h1555, 1'b1, 1'b0);
        lock[3] = 1'b0;
        settle();
        put(16'h1f80, 14'h0000, 1'b0, 1'b1);
        put(16'h1fff, 14'h0000, 1'b0, 1'b1);
        put(16'h1f7f, 14'h1555, 1'b1, 1'b0);
        fetch_at(15'h1f80, 14'h2aaa, 1'b1);
        @(negedge clock);
        eset = 1'b1;
        @(negedge clock);
        eset = 1'b0;
        check(evf, 1'b1);
        fetch_at(15'h1f7f, 14'h1555, 1'b0);
        store_n = 1'b1;
        lock[3] = 1'b1;
        erase();
        $display("Test storage done");
        boot_n = 1'b0;
        lock[1] = 1'b0;
        foreach (size_codes[k])
        begin
            size = size_codes[k];
            settle();
            put(boot_last(size), 14'h0011, 1'b0, 1'b1);
            put(boot_last(size) + 16'h0001, 14'h0022, 1'b1, 1'b0);
        end
        $display("Test boot done");
        complete_run();
    end
endmodule
